// File: ppms_mode_switch.sv
// speed loop P / PI mode switching with AXI4-Lite parameter registers
//
// How it works
// R1: selector 0 compares the internal torque reference with the torque level.
// R2: selector 1 compares the speed reference with the speed level for the motor type.
// R3: selector 2 compares acceleration with the acceleration level for the motor type.
// R4: selector 3 compares the position deviation with the deviation level.
// R5: selector 4 never puts the speed loop into proportional-only control.
// R6: torque at or above the torque level (0 to 800 %) selects proportional-only control.
// R7: the torque level resets to 200 %.
// R8: rotary speed at or above the rotary speed level (0 to 10000, reset 0) selects P control.
// R9: linear speed at or above the linear speed level (0 to 10000 mm/s) selects P control.
// R10: rotary acceleration at or above its level (0 to 30000, reset 0) selects P control.
// R11: linear acceleration at or above its level (0 to 30000, reset 0) selects P control.
// R12: deviation at or above the deviation level (0 to 10000, reset 0) selects P control.
// R13: the deviation trigger acts only in position control mode.
// R14: the position loop integral time constant is 0 to 50000 in 0.1 ms steps, reset 0.
// R15: below the level the loop runs PI, and new settings act on the next control cycle.
`timescale 1ns/1ps
`include "ppms_params.svh"

module ppms_mode_switch (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control loop
    input wire logic ctrl_cycle,
    input wire ppms_pkg::ppms_loop_in_t loop_in,
    output ppms_pkg::ppms_loop_out_t loop_out,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    logic [`PPMS_SEL_W-1:0] select_reg;
    logic [15:0] torque_level_reg;
    logic [15:0] speed_rot_reg;
    logic [15:0] accel_rot_reg;
    logic [15:0] dev_level_reg;
    logic [15:0] speed_lin_reg;
    logic [15:0] accel_lin_reg;
    logic [15:0] pos_ti_reg;
    logic linear_reg;
    logic posmode_reg;

    // write and read channel holding registers
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg;
    logic bvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rvalid_reg;

    logic do_write;
    logic [15:0] wval;
    logic wr_hit;

    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    // a write lands only once both halves are held and the last answer has gone
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    // a lane without its strobe writes zero rather than keeping stale bits
    for (genvar lane = 0; lane < 2; lane++) begin : g_lane
        assign wval[8*lane +: 8] = w_strb_reg[lane] ? w_data_reg[8*lane +: 8] : 8'h00;
    end
    assign s_axi_bresp = bresp_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rvalid = rvalid_reg;

    // address and data are caught independently, in either order
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    // values above the documented range are refused with slverr and leave the register alone
    always_comb begin
        unique case (aw_addr_reg)
            `PPMS_OFS_SELECT: wr_hit = wval <= 16'(ppms_pkg::PPMS_TRIG_NONE);
            `PPMS_OFS_TORQUE: wr_hit = wval <= `PPMS_MAX_TORQUE;
            `PPMS_OFS_SPD_ROT: wr_hit = wval <= `PPMS_MAX_SPEED;
            `PPMS_OFS_ACC_ROT: wr_hit = wval <= `PPMS_MAX_ACCEL;
            `PPMS_OFS_DEV: wr_hit = wval <= `PPMS_MAX_DEV;
            `PPMS_OFS_SPD_LIN: wr_hit = wval <= `PPMS_MAX_SPEED;
            `PPMS_OFS_ACC_LIN: wr_hit = wval <= `PPMS_MAX_ACCEL;
            `PPMS_OFS_POS_TI: wr_hit = wval <= `PPMS_MAX_POS_TI;
            `PPMS_OFS_CTRL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // the code only matters while bvalid stands, so it is left alone after the handshake
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bresp_reg <= `PPMS_RESP_OKAY;
        end else if (do_write) begin
            bresp_reg <= wr_hit ? `PPMS_RESP_OKAY : `PPMS_RESP_SLVERR;
        end
    end

    // one strobe per register keeps each register in a process of its own
    localparam logic [15:0] sel_rst_word = `PPMS_RST_SELECT;

    logic we_any;
    logic we_select;
    logic we_torque;
    logic we_spd_rot;
    logic we_acc_rot;
    logic we_dev;
    logic we_spd_lin;
    logic we_acc_lin;
    logic we_pos_ti;
    logic we_ctrl;

    // refused writes raise no strobe, so an out-of-range value never reaches a register
    assign we_any = do_write && wr_hit;
    assign we_select = we_any && (aw_addr_reg == `PPMS_OFS_SELECT);
    assign we_torque = we_any && (aw_addr_reg == `PPMS_OFS_TORQUE);
    assign we_spd_rot = we_any && (aw_addr_reg == `PPMS_OFS_SPD_ROT);
    assign we_acc_rot = we_any && (aw_addr_reg == `PPMS_OFS_ACC_ROT);
    assign we_dev = we_any && (aw_addr_reg == `PPMS_OFS_DEV);
    assign we_spd_lin = we_any && (aw_addr_reg == `PPMS_OFS_SPD_LIN);
    assign we_acc_lin = we_any && (aw_addr_reg == `PPMS_OFS_ACC_LIN);
    assign we_pos_ti = we_any && (aw_addr_reg == `PPMS_OFS_POS_TI);
    assign we_ctrl = we_any && (aw_addr_reg == `PPMS_OFS_CTRL);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            select_reg <= sel_rst_word[`PPMS_SEL_W-1:0];
        end else if (we_select) begin
            select_reg <= wval[`PPMS_SEL_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            torque_level_reg <= `PPMS_RST_TORQUE; // R7
        end else if (we_torque) begin
            torque_level_reg <= wval; // R6
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            speed_rot_reg <= `PPMS_RST_LEVEL; // R8
        end else if (we_spd_rot) begin
            speed_rot_reg <= wval; // R8
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            accel_rot_reg <= `PPMS_RST_LEVEL; // R10
        end else if (we_acc_rot) begin
            accel_rot_reg <= wval; // R10
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dev_level_reg <= `PPMS_RST_LEVEL; // R12
        end else if (we_dev) begin
            dev_level_reg <= wval; // R12
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            speed_lin_reg <= `PPMS_RST_LEVEL;
        end else if (we_spd_lin) begin
            speed_lin_reg <= wval; // R9
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            accel_lin_reg <= `PPMS_RST_LEVEL; // R11
        end else if (we_acc_lin) begin
            accel_lin_reg <= wval; // R11
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pos_ti_reg <= `PPMS_RST_POS_TI; // R14
        end else if (we_pos_ti) begin
            pos_ti_reg <= wval; // R14
        end
    end

    // motor type and control mode come from the host, as this block cannot see them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            linear_reg <= 1'b0;
            posmode_reg <= 1'b0;
        end else if (we_ctrl) begin
            linear_reg <= wval[`PPMS_CTRL_LINEAR_BIT];
            posmode_reg <= wval[`PPMS_CTRL_POSMODE_BIT];
        end
    end

    // decision state; p_only_reg is updated once per control cycle, level, quantity and trig_active follow their inputs
    logic p_only_reg;
    logic [15:0] level;
    logic [31:0] quantity;
    logic trig_active;

    // the word follows the offered address and is caught only at the edge that takes it
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    // read mux; unmapped offsets answer zero with slverr
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = `PPMS_RESP_OKAY;
        unique case (s_axi_araddr)
            `PPMS_OFS_SELECT: rd_word = {29'h0, select_reg};
            `PPMS_OFS_TORQUE: rd_word = {16'h0, torque_level_reg};
            `PPMS_OFS_SPD_ROT: rd_word = {16'h0, speed_rot_reg};
            `PPMS_OFS_ACC_ROT: rd_word = {16'h0, accel_rot_reg};
            `PPMS_OFS_DEV: rd_word = {16'h0, dev_level_reg};
            `PPMS_OFS_SPD_LIN: rd_word = {16'h0, speed_lin_reg};
            `PPMS_OFS_ACC_LIN: rd_word = {16'h0, accel_lin_reg};
            `PPMS_OFS_POS_TI: rd_word = {16'h0, pos_ti_reg};
            `PPMS_OFS_CTRL: rd_word = {30'h0, posmode_reg, linear_reg};
            `PPMS_OFS_STATUS: rd_word = {30'h0, trig_active, p_only_reg};
            default: rd_resp = `PPMS_RESP_SLVERR;
        endcase
    end

    // read path; answer one cycle after the address is taken
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `PPMS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_resp;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // pick trigger quantity and level
    always_comb begin
        level = 16'h0000;
        quantity = 32'h0000_0000;
        trig_active = 1'b1;
        unique case (select_reg)
            3'(ppms_pkg::PPMS_TRIG_TORQUE): begin
                quantity = {16'h0, loop_in.torque_ref}; // R1
                level = torque_level_reg; // R6
            end
            3'(ppms_pkg::PPMS_TRIG_SPEED): begin
                quantity = {16'h0, loop_in.speed_ref}; // R2
                level = linear_reg ? speed_lin_reg : speed_rot_reg; // R8 R9
            end
            3'(ppms_pkg::PPMS_TRIG_ACCEL): begin
                quantity = {16'h0, loop_in.accel}; // R3
                level = linear_reg ? accel_lin_reg : accel_rot_reg; // R10 R11
            end
            // compared at full width, so a large error never wraps below the level
            3'(ppms_pkg::PPMS_TRIG_DEVIATION): begin
                quantity = loop_in.pos_deviation; // R4
                level = dev_level_reg; // R12
                trig_active = posmode_reg; // R13
            end
            default: trig_active = 1'b0; // R5
        endcase
    end

    // equal counts as reached; settings are sampled at the next control cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            p_only_reg <= 1'b0;
        end else if (ctrl_cycle) begin
            p_only_reg <= trig_active && (quantity >= {16'h0, level}); // R6 R15
        end
    end

    // position integral time base: one tick per 0.1 ms
    // it runs free from reset, so the first tick comes 0.1 ms after reset
    logic [15:0] tick_cnt_reg;
    logic tick_reg;
    logic tick_wrap;

    assign tick_wrap = tick_cnt_reg == 16'(`PPMS_TI_UNIT_CYC - 1);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 16'h0000;
        end else if (tick_wrap) begin
            tick_cnt_reg <= 16'h0000;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tick_wrap; // R14
        end
    end

    assign loop_out.p_only = p_only_reg; // R15
    assign loop_out.integral_enable = !p_only_reg; // R15
    assign loop_out.pos_integral_tc = pos_ti_reg; // R14
    assign loop_out.pos_integral_tick = tick_reg;

endmodule : ppms_mode_switch

// File: ppms_params.svh
// register offsets, reset values, ranges and timing constants of the mode switching block
`ifndef PPMS_PARAMS_SVH
`define PPMS_PARAMS_SVH

`define PPMS_OFS_SELECT 8'h00
`define PPMS_OFS_TORQUE 8'h04
`define PPMS_OFS_SPD_ROT 8'h08
`define PPMS_OFS_ACC_ROT 8'h0c
`define PPMS_OFS_DEV 8'h10
`define PPMS_OFS_SPD_LIN 8'h14
`define PPMS_OFS_ACC_LIN 8'h18
`define PPMS_OFS_POS_TI 8'h1c
`define PPMS_OFS_CTRL 8'h20
`define PPMS_OFS_STATUS 8'h24

`define PPMS_RST_SELECT 16'h0000
`define PPMS_RST_TORQUE 16'h00c8
`define PPMS_RST_LEVEL 16'h0000
`define PPMS_RST_POS_TI 16'h0000

`define PPMS_MAX_TORQUE 16'h0320
`define PPMS_MAX_SPEED 16'h2710
`define PPMS_MAX_ACCEL 16'h7530
`define PPMS_MAX_DEV 16'h2710
`define PPMS_MAX_POS_TI 16'hc350

`define PPMS_SEL_W 3
`define PPMS_CTRL_LINEAR_BIT 0
`define PPMS_CTRL_POSMODE_BIT 1

// position integral time constant is in 0.1 ms units; clock period in ns
`define PPMS_TI_UNIT_NS 100000
`define PPMS_CLK_PERIOD_NS 100
`define PPMS_TI_UNIT_CYC (`PPMS_TI_UNIT_NS / `PPMS_CLK_PERIOD_NS)

`define PPMS_RESP_OKAY 2'b00
`define PPMS_RESP_SLVERR 2'b10

`endif

// File: ppms_pkg.sv
// types of the mode switching block
package ppms_pkg;

    typedef enum logic [2:0] {
        PPMS_TRIG_TORQUE = 3'h0,
        PPMS_TRIG_SPEED = 3'h1,
        PPMS_TRIG_ACCEL = 3'h2,
        PPMS_TRIG_DEVIATION = 3'h3,
        PPMS_TRIG_NONE = 3'h4
    } ppms_trig_t;

    // quantities sampled from the control loop each control cycle
    typedef struct packed {
        logic [15:0] torque_ref;
        logic [15:0] speed_ref;
        logic [15:0] accel;
        logic [31:0] pos_deviation;
    } ppms_loop_in_t;

    typedef struct packed {
        logic p_only;
        logic integral_enable;
        logic [15:0] pos_integral_tc;
        logic pos_integral_tick;
    } ppms_loop_out_t;

endpackage : ppms_pkg

// File: ppms_mode_switch_properties.sv
// concurrent checks on the ports of the mode switching block
`timescale 1ns/1ps
`include "ppms_params.svh"
module ppms_mode_switch_properties (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control loop
    input wire logic ctrl_cycle,
    input wire ppms_pkg::ppms_loop_out_t loop_out,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // the tick phase is unknown until the first one, so only later ticks are timed
    logic [9:0] tick_cnt_reg;
    logic tick_seen_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 10'h000;
            tick_seen_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= loop_out.pos_integral_tick ? 10'h000 : tick_cnt_reg + 10'h001;
            tick_seen_reg <= tick_seen_reg | loop_out.pos_integral_tick;
        end
    end

    property p_pi_inverse;
        loop_out.integral_enable == !loop_out.p_only;
    endproperty
    a_pi_inverse: assert property (p_pi_inverse) else $error("pi enable mismatch");
    property p_mode_hold;
        !ctrl_cycle |=> $stable(loop_out.p_only);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved off cycle");
    property p_tick_period;
        tick_seen_reg |->
            (loop_out.pos_integral_tick == (tick_cnt_reg == 10'(`PPMS_TI_UNIT_CYC - 1)));
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read data late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
endmodule : ppms_mode_switch_properties

// File: ppms_mode_switch_tb_top.sv
// self-checking bench of the mode switching block
`timescale 1ns/1ps
`include "ppms_params.svh"
module ppms_mode_switch_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ctrl_cycle = 1'b0;
    ppms_pkg::ppms_loop_in_t loop_in = '0;
    ppms_pkg::ppms_loop_out_t loop_out;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cc_d = 1'b0;
    logic pe;
    logic [1:0] bresp, rresp;
    int err_total = 0;
    int n_compared = 0;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic pq[$];

    always #50 clock = ~clock;

    ppms_mode_switch i_ppms_mode_switch (.clock(clock), .rst_n(rst_n), .ctrl_cycle(ctrl_cycle),
        .loop_in(loop_in), .loop_out(loop_out), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic chk(string name, logic [33:0] exp, logic [33:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    // results are sampled at the edge that completes them, before that edge's updates
    always @(posedge clock) begin
        if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
        if (rvalid && rready) chk("rdata", rq.pop_front(), {rresp, rdata});
        if (cc_d) begin
            pe = pq.pop_front();
            chk("p_only", {33'h0, pe}, {33'h0, loop_out.p_only});
            chk("integral_enable", {33'h0, !pe}, {33'h0, loop_out.integral_enable});
        end
        cc_d = ctrl_cycle;
    end

    task automatic wr(logic [7:0] a, logic [15:0] d, logic [1:0] r);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        bq.push_back(r);
        @(posedge clock);
        awaddr <= a;
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge clock);
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clock); while (!bvalid);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r);
        rq.push_back({r, e});
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        rready <= 1'b0;
    endtask : rd

    // unselected quantities sit on the side that would flip the expected mode
    task automatic pulse(logic [2:0] sel, logic [15:0] v, logic e);
        logic [15:0] o;
        o = e ? 16'h0000 : 16'hffff;
        @(posedge clock);
        loop_in <= {sel == 3'h0 ? v : o, sel == 3'h1 ? v : o, sel == 3'h2 ? v : o,
                    sel == 3'h3 ? {16'h0, v} : {o, o}};
        ctrl_cycle <= 1'b1;
        pq.push_back(e);
        @(posedge clock);
        ctrl_cycle <= 1'b0;
        @(posedge clock);
    endtask : pulse

    task automatic run(logic [2:0] sel, logic [1:0] mode, logic [7:0] la, logic [15:0] mx,
                       logic en);
        logic [15:0] lvl, v;
        lvl = 16'(1 + $urandom % (mx - 1));
        wr(`PPMS_OFS_CTRL, {14'h0, mode}, `PPMS_RESP_OKAY);
        wr(`PPMS_OFS_SELECT, {13'h0, sel}, `PPMS_RESP_OKAY);
        wr(la, lvl, `PPMS_RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            v = (k == 3) ? 16'($urandom) : lvl + 16'(k) - 16'h1;
            pulse(sel, v, en && (v >= lvl));
        end
        rd(`PPMS_OFS_STATUS, {30'h0, en, en && (v >= lvl)}, `PPMS_RESP_OKAY);
    endtask : run

    initial begin
        void'($urandom(32'h6482f17d));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), i == 1 ? 32'hc8 : 32'h0, `PPMS_RESP_OKAY);
        end
        rd(8'h40, 32'h0, `PPMS_RESP_SLVERR);
        wr(`PPMS_OFS_TORQUE, 16'h0321, `PPMS_RESP_SLVERR);
        wr(`PPMS_OFS_SELECT, 16'h0005, `PPMS_RESP_SLVERR);
        wr(`PPMS_OFS_POS_TI, `PPMS_MAX_POS_TI, `PPMS_RESP_OKAY);
        chk("integral_tc", {18'h0, `PPMS_MAX_POS_TI}, {18'h0, loop_out.pos_integral_tc});
        rd(`PPMS_OFS_POS_TI, {16'h0, `PPMS_MAX_POS_TI}, `PPMS_RESP_OKAY);
        rd(`PPMS_OFS_TORQUE, 32'hc8, `PPMS_RESP_OKAY);
        run(3'h0, 2'h0, `PPMS_OFS_TORQUE, `PPMS_MAX_TORQUE, 1'b1);
        run(3'h1, 2'h0, `PPMS_OFS_SPD_ROT, `PPMS_MAX_SPEED, 1'b1);
        run(3'h1, 2'h1, `PPMS_OFS_SPD_LIN, `PPMS_MAX_SPEED, 1'b1);
        run(3'h2, 2'h0, `PPMS_OFS_ACC_ROT, `PPMS_MAX_ACCEL, 1'b1);
        run(3'h2, 2'h1, `PPMS_OFS_ACC_LIN, `PPMS_MAX_ACCEL, 1'b1);
        run(3'h3, 2'h2, `PPMS_OFS_DEV, `PPMS_MAX_DEV, 1'b1);
        run(3'h3, 2'h0, `PPMS_OFS_DEV, `PPMS_MAX_DEV, 1'b0);
        run(3'h4, 2'h2, `PPMS_OFS_TORQUE, `PPMS_MAX_TORQUE, 1'b0);
        repeat (2100) @(posedge clock);
        results();
    end

    initial begin
        repeat (30000) @(posedge clock);
        err_total++;
        results();
    end
endmodule : ppms_mode_switch_tb_top

bind ppms_mode_switch ppms_mode_switch_properties i_ppms_mode_switch_properties (
    .clock(clock), .rst_n(rst_n), .ctrl_cycle(ctrl_cycle), .loop_out(loop_out),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
